// *** design/gpi_cfg.svh ***
`ifndef GPI_CFG_SVH
`define GPI_CFG_SVH

// Clock periods in nanoseconds
`define GPI_SYS_PERIOD_NS 40
`define GPI_LINK_PERIOD_NS 320
// System clocks per half link period, also one data beat
`define GPI_HALF_CYCLES (`GPI_LINK_PERIOD_NS / (2 * `GPI_SYS_PERIOD_NS))
// Beats in one burst
`define GPI_BURST_BEATS 4

// Command codes: chip select, row, column, write-command levels
`define GPI_CODE_LMR 4'h0
`define GPI_CODE_REF 4'h1
`define GPI_CODE_PRE 4'h2
`define GPI_CODE_ACT 4'h3
`define GPI_CODE_WR 4'h4
`define GPI_CODE_RD 4'h5
`define GPI_CODE_BST 4'h6
`define GPI_CODE_NOP 4'h7
`define GPI_CODE_DESEL 4'hF

// Address bit that flags auto precharge / precharge all
`define GPI_AP_BIT 8
// Bank-select low bits that pick a mode register
`define GPI_MR_BASE 2'h0
`define GPI_MR_EXT 2'h1

// Power state codes, one-hot
`define GPI_PWR_ACTIVE 4'h1
`define GPI_PWR_PD_PRE 4'h2
`define GPI_PWR_PD_ACT 4'h4
`define GPI_PWR_SELF 4'h8

`endif

// *** design/gpi_ctrl.sv ***
`timescale 1ns/1ps
`include "gpi_cfg.svh"

module gpi_ctrl
(
    input logic sys_clk,
    input logic rst,
    gpi_link_if.ctrl link,
    input logic reqValid,
    input gpi_pkg::gpi_cmd_t reqCmd,
    input logic [2:0] reqBank,
    input logic [11:0] reqAddr,
    input logic [127:0] reqData,
    input logic [15:0] reqMask,
    input logic gateReq,
    input logic scanReq,
    output logic reqReady,
    output logic [127:0] rdData,
    output logic rdValid
);
    import gpi_pkg::*;

    // Link clock divider
    logic [1:0] divCnt;
    // Write burst state
    logic wrBusy;
    logic [2:0] wrBeat;
    logic [127:0] wrData;
    logic [15:0] wrMask;
    // Read capture state
    logic rdWait;
    logic [1:0] rdBeat;
    // Read pin synchronisers
    logic [35:0] syncA;
    logic [35:0] syncB;
    logic strobePrev;

    wire halfEnd = divCnt == 2'(`GPI_HALF_CYCLES - 1);
    wire fallNow = halfEnd & link.diffClockTrue;
    // Mid-beat point for the write strobe
    wire midBeat = divCnt == 2'(`GPI_HALF_CYCLES / 2 - 1);
    wire idle = ~wrBusy & ~rdWait;
    wire take = fallNow & reqReady & reqValid;
    wire rdEdge = syncB[32] ^ strobePrev;
    // Command code now on the pins
    wire [3:0] pinCode = {link.chipSelN, link.rowStrobeN, link.colStrobeN,
                          link.writeCmdN};
    // A refresh left up while the gate drops is seen with the gate low,
    // which is how the device tells self refresh from power-down
    wire holdRef = idle & ~take & link.clockGate & ~gateReq
                   & (pinCode == `GPI_CODE_REF);

    // Clock divider; pins change half a period before sampling
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            divCnt <= 2'h0;
            link.diffClockTrue <= 1'b0;
            link.diffClockComp <= 1'b1;
        end
        else
        begin
            divCnt <= halfEnd ? 2'h0 : 2'(divCnt + 2'h1);
            if (halfEnd)
            begin
                link.diffClockTrue <= ~link.diffClockTrue;
                link.diffClockComp <= link.diffClockTrue;
            end
        end
    end

    // Command pins and clock gate
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            {link.chipSelN, link.rowStrobeN, link.colStrobeN,
             link.writeCmdN} <= `GPI_CODE_DESEL;
            link.bank_select <= 3'h0;
            link.address_inputs <= 12'h000;
            link.clockGate <= 1'b1;
            link.scan_mode_pin <= 1'b0;
            reqReady <= 1'b0;
        end
        else
        begin
            // Scan pin held low unless asked for
            link.scan_mode_pin <= scanReq;
            // Ready only in the cycle before a falling edge
            reqReady <= (divCnt == 2'(`GPI_HALF_CYCLES - 2))
                        & link.diffClockTrue & idle & link.clockGate
                        & gateReq & ~scanReq;
            if (fallNow)
            begin
                // Gate moves only between accesses
                if (idle && !take)
                    link.clockGate <= gateReq;
                {link.chipSelN, link.rowStrobeN, link.colStrobeN,
                 link.writeCmdN} <= take ? reqCmd :
                                    (holdRef ? GPI_CMD_REF : GPI_CMD_NOP);
                link.bank_select <= reqBank;
                link.address_inputs <= reqAddr;
            end
        end
    end

    // Write beats: data at half-period start, strobe in the middle
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wrBusy <= 1'b0;
            wrBeat <= 3'h0;
            wrData <= 128'h0;
            wrMask <= 16'h0000;
            link.ctrlDataOe <= 1'b0;
            link.ctrlData <= 32'h0000_0000;
            link.byte_write_mask <= 4'h0;
            link.write_strobe <= 4'h0;
        end
        else if (take && reqCmd == GPI_CMD_WR)
        begin
            wrBusy <= 1'b1;
            wrBeat <= 3'h0;
            wrData <= reqData;
            wrMask <= reqMask;
        end
        else if (wrBusy)
        begin
            if (halfEnd && wrBeat < 3'(`GPI_BURST_BEATS))
            begin
                // Beat 0 sits in the low word and low mask nibble
                link.ctrlDataOe <= 1'b1;
                link.ctrlData <= wrData[32*wrBeat[1:0] +: 32];
                link.byte_write_mask <= wrMask[4*wrBeat[1:0] +: 4];
                wrBeat <= 3'(wrBeat + 3'h1);
            end
            else if (halfEnd)
            begin
                link.ctrlDataOe <= 1'b0;
                wrBusy <= 1'b0;
            end
            else if (midBeat && link.ctrlDataOe)
                link.write_strobe <= ~link.write_strobe;
        end
    end

    // Read capture on each synchronised strobe edge
    always_ff @(posedge sys_clk)
    begin
        syncA <= {link.read_strobe[3:0], link.data_lines};
        syncB <= syncA;
        strobePrev <= syncB[32];
        if (rst)
        begin
            rdWait <= 1'b0;
            rdBeat <= 2'h0;
            rdValid <= 1'b0;
            rdData <= 128'h0;
        end
        else
        begin
            rdValid <= 1'b0;
            if (take && reqCmd == GPI_CMD_RD)
            begin
                rdWait <= 1'b1;
                rdBeat <= 2'h0;
            end
            else if (rdWait && rdEdge)
            begin
                // Edge-aligned data is already settled here
                rdData[32*rdBeat +: 32] <= syncB[31:0];
                rdBeat <= 2'(rdBeat + 2'h1);
                if (rdBeat == 2'h3)
                begin
                    rdWait <= 1'b0;
                    rdValid <= 1'b1;
                end
            end
        end
    end
endmodule

// *** design/gpi_device.sv ***
`timescale 1ns/1ps
`include "gpi_cfg.svh"
module gpi_device
(
    input logic sys_clk,
    input logic rst,
    gpi_link_if.device link,
    output gpi_pkg::gpi_power_t powerState,
    output logic cmdStrobe,
    output gpi_pkg::gpi_cmd_t cmdCode,
    output logic [7:0] openBanks,
    output logic [11:0] modeReg,
    output logic [11:0] extModeReg,
    output logic scanActive
);
    import gpi_pkg::*;

    // Pin synchronisers, all pins in one vector
    logic [62:0] syncA;
    logic [62:0] syncB;
    // Synchronised pin views
    logic ckT, ckC, ckeS, scanS;
    logic [3:0] cmdPins;
    logic [2:0] bankS;
    logic [11:0] addrS;
    logic [3:0] maskS;
    logic [3:0] wStrobeS;
    logic [31:0] dataS;
    // Edge history of the link clock and strobes
    logic ckTPrev;
    logic ckCPrev;
    logic [3:0] wStrobePrev;
    // Row state per bank
    logic [7:0] bankOpen;
    logic [11:0] openRow [0:7];
    // Small data store
    logic [31:0] mem [0:15];
    // Read burst state
    logic rdBusy;
    logic [2:0] rdBeat;
    logic [1:0] rdTimer;
    logic [3:0] rdCol;
    // Write burst state
    logic wrBusy;
    logic [1:0] wrBeat;
    logic [3:0] wrCol;
    gpi_power_t next_powerState;

    // Wrap a column plus beat number into the store
    function automatic logic [3:0] beatIndex(input logic [3:0] col,
                                             input logic [1:0] beat);
        return 4'(col + {2'h0, beat});
    endfunction

    assign {ckT, ckC, ckeS, cmdPins, bankS, addrS, maskS, wStrobeS,
            scanS, dataS} = syncB;

    // Command sampled on true rising while complement falls
    wire linkRise = ckT & ~ckTPrev & ~ckC & ckCPrev;
    // Self refresh even ignores clock inputs
    wire clockSeen = linkRise & (powerState != GPI_SELF);
    wire gpi_cmd_t cmdNow = gpi_decode(cmdPins);
    // Decoder live only when awake, gated on and not scanning
    wire cmdTake = clockSeen & ckeS & ~scanS
                   & (powerState == GPI_ACTIVE)
                   & (cmdNow != GPI_CMD_DESEL);
    wire apFlag = addrS[`GPI_AP_BIT];
    wire [3:0] wEdge = wStrobeS ^ wStrobePrev;
    wire rdStep = rdBusy & (rdTimer == 2'h0);

    // Two flops before any logic reads a pin
    always_ff @(posedge sys_clk)
    begin
        syncA <= {link.diffClockTrue, link.diffClockComp, link.clockGate,
                  link.chipSelN, link.rowStrobeN, link.colStrobeN,
                  link.writeCmdN, link.bank_select, link.address_inputs,
                  link.byte_write_mask, link.write_strobe,
                  link.scan_mode_pin, link.data_lines};
        syncB <= syncA;
        ckTPrev <= ckT;
        ckCPrev <= ckC;
        wStrobePrev <= wStrobeS;
    end

    // Power state choice
    always_comb
    begin
        next_powerState = powerState;
        unique case (powerState)
            GPI_ACTIVE:
            begin
                // Entry only on a link edge with gate low
                if (clockSeen && !ckeS)
                begin
                    if (cmdNow == GPI_CMD_REF && !scanS)
                        next_powerState = GPI_SELF;
                    else if (|bankOpen)
                        next_powerState = GPI_PD_ACT;
                    else
                        next_powerState = GPI_PD_PRE;
                end
            end
            GPI_PD_PRE, GPI_PD_ACT:
            begin
                // Exit also waits for a link edge
                if (clockSeen && ckeS)
                    next_powerState = GPI_ACTIVE;
            end
            GPI_SELF:
            begin
                // Gate alone wakes it, no clock needed
                if (ckeS)
                    next_powerState = GPI_ACTIVE;
            end
        endcase
    end

    // Power state, command report and scan flag
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            powerState <= GPI_ACTIVE;
            cmdStrobe <= 1'b0;
            cmdCode <= GPI_CMD_DESEL;
            scanActive <= 1'b0;
        end
        else
        begin
            powerState <= next_powerState;
            cmdStrobe <= cmdTake;
            if (cmdTake)
                cmdCode <= cmdNow;
            scanActive <= scanS;
        end
    end

    // Bank rows and mode registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bankOpen <= 8'h00;
            modeReg <= 12'h000;
            extModeReg <= 12'h000;
        end
        else if (cmdTake)
        begin
            unique case (cmdNow)
                GPI_CMD_ACT:
                begin
                    // Three bank bits, twelve row bits
                    bankOpen[bankS] <= 1'b1;
                    openRow[bankS] <= addrS;
                end
                GPI_CMD_PRE:
                begin
                    if (apFlag)
                        bankOpen <= 8'h00;
                    else
                        bankOpen[bankS] <= 1'b0;
                end
                GPI_CMD_RD, GPI_CMD_WR:
                begin
                    // Auto precharge closes the row at once here
                    if (apFlag)
                        bankOpen[bankS] <= 1'b0;
                end
                GPI_CMD_LMR:
                begin
                    // Op-code from address, register by bank bits
                    if (bankS[1:0] == `GPI_MR_BASE)
                        modeReg <= addrS;
                    else if (bankS[1:0] == `GPI_MR_EXT)
                        extModeReg <= addrS;
                end
                default:
                begin
                    // Refresh, burst stop and nop leave rows alone
                end
            endcase
        end
    end

    // Write bursts; each lane uses its own strobe and mask
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wrBusy <= 1'b0;
            wrBeat <= 2'h0;
            wrCol <= 4'h0;
        end
        else if (cmdTake && cmdNow == GPI_CMD_WR)
        begin
            wrBusy <= 1'b1;
            wrBeat <= 2'h0;
            wrCol <= addrS[3:0];
        end
        else if (wrBusy)
        begin
            for (int l = 0; l < 4; l++)
            begin
                // Masked byte lanes never reach the store
                if (wEdge[l] && !maskS[l])
                    mem[beatIndex(wrCol, wrBeat)][8*l +: 8] <=
                        dataS[8*l +: 8];
            end
            if (wEdge[0])
            begin
                wrBeat <= 2'(wrBeat + 2'h1);
                if (wrBeat == 2'h3)
                    wrBusy <= 1'b0;
            end
        end
    end

    // Read bursts; strobe flips in the same cycle as the data
    always_ff @(posedge sys_clk)
    begin
        if (rst || !ckeS || scanS)
        begin
            // Gate low kills the drivers without a link edge
            rdBusy <= 1'b0;
            link.devDataOe <= 1'b0;
            link.read_strobe <= 4'h0;
            link.devData <= 32'h0000_0000;
            rdBeat <= 3'h0;
            rdTimer <= 2'h0;
            rdCol <= 4'h0;
        end
        else if (cmdTake && cmdNow == GPI_CMD_RD)
        begin
            rdBusy <= 1'b1;
            rdBeat <= 3'h0;
            rdTimer <= 2'h0;
            rdCol <= addrS[3:0];
        end
        else if (rdBusy)
        begin
            rdTimer <= 2'(rdTimer + 2'h1);
            if (rdStep && rdBeat < 3'(`GPI_BURST_BEATS))
            begin
                link.devDataOe <= 1'b1;
                link.devData <= mem[beatIndex(rdCol, rdBeat[1:0])];
                link.read_strobe <= ~link.read_strobe;
                rdBeat <= 3'(rdBeat + 3'h1);
            end
            else if (rdStep)
            begin
                // Last beat has had its full slot
                link.devDataOe <= 1'b0;
                rdBusy <= 1'b0;
            end
        end
    end

    assign openBanks = bankOpen;
endmodule

// *** design/gpi_link_if.sv ***
`timescale 1ns/1ps

interface gpi_link_if;
    logic diffClockTrue; // Link clock, true phase
    logic diffClockComp; // Link clock, complement phase
    logic clockGate; // Clock enable
    logic chipSelN; // Chip select, active low
    logic rowStrobeN; // Row strobe, active low
    logic colStrobeN; // Column strobe, active low
    logic writeCmdN; // Write command, active low
    logic [2:0] bank_select; // Bank choice
    logic [11:0] address_inputs; // Row, column or op-code
    logic [3:0] byte_write_mask; // Per-lane write mask
    logic [3:0] write_strobe; // Per-lane write strobe
    logic [3:0] read_strobe; // Per-lane read strobe
    logic scan_mode_pin; // Boundary scan enable
    logic [31:0] ctrlData; // Controller data drive
    logic ctrlDataOe; // Controller drives data
    logic [31:0] devData; // Device data drive
    logic devDataOe; // Device drives data
    logic [31:0] data_lines; // Resolved data wire

    // Wire level from whichever end drives; undriven reads zero
    assign data_lines = devDataOe ? devData :
                        (ctrlDataOe ? ctrlData : 32'h0000_0000);

    modport device (
        input diffClockTrue, diffClockComp, clockGate, chipSelN,
        input rowStrobeN, colStrobeN, writeCmdN, bank_select,
        input address_inputs, byte_write_mask, write_strobe,
        input scan_mode_pin, data_lines,
        output read_strobe, devData, devDataOe
    );

    modport ctrl (
        output diffClockTrue, diffClockComp, clockGate, chipSelN,
        output rowStrobeN, colStrobeN, writeCmdN, bank_select,
        output address_inputs, byte_write_mask, write_strobe,
        output scan_mode_pin, ctrlData, ctrlDataOe,
        input read_strobe, data_lines
    );
endinterface

// *** design/gpi_pkg.sv ***
`include "gpi_cfg.svh"

package gpi_pkg;
    // Command set as seen on the command pins
    typedef enum logic [3:0] {
        GPI_CMD_LMR = `GPI_CODE_LMR,
        GPI_CMD_REF = `GPI_CODE_REF,
        GPI_CMD_PRE = `GPI_CODE_PRE,
        GPI_CMD_ACT = `GPI_CODE_ACT,
        GPI_CMD_WR = `GPI_CODE_WR,
        GPI_CMD_RD = `GPI_CODE_RD,
        GPI_CMD_BST = `GPI_CODE_BST,
        GPI_CMD_NOP = `GPI_CODE_NOP,
        GPI_CMD_DESEL = `GPI_CODE_DESEL
    } gpi_cmd_t;

    // Device power states
    typedef enum logic [3:0] {
        GPI_ACTIVE = `GPI_PWR_ACTIVE,
        GPI_PD_PRE = `GPI_PWR_PD_PRE,
        GPI_PD_ACT = `GPI_PWR_PD_ACT,
        GPI_SELF = `GPI_PWR_SELF
    } gpi_power_t;

    // Four registered levels into one command; select high masks all
    function automatic gpi_cmd_t gpi_decode(input logic [3:0] pins);
        gpi_cmd_t cmd;
        cmd = GPI_CMD_DESEL;
        if (!pins[3])
        begin
            cmd = gpi_cmd_t'(pins);
        end
        return cmd;
    endfunction
endpackage

// *** sim/gpi_link_chk.sv ***
`timescale 1ns/1ps
// Watches only the wires between the two ends
module gpi_link_chk
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic diffClockTrue,
    input wire logic diffClockComp,
    input wire logic clockGate,
    input wire logic chipSelN,
    input wire logic [3:0] write_strobe,
    input wire logic [3:0] read_strobe,
    input wire logic scan_mode_pin,
    input wire logic [31:0] ctrlData,
    input wire logic ctrlDataOe,
    input wire logic devDataOe
);
    // Single domain, so one clock and one reset for all
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_comp_inverse: assert property (diffClockComp != diffClockTrue)
        else $error("link clock phases not opposite");
    a_high_four: assert property ($rose(diffClockTrue) |->
        diffClockTrue [*4] ##1 !diffClockTrue)
        else $error("link clock high phase not four cycles");
    a_cmd_at_fall: assert property ($changed(chipSelN) |->
        $fell(diffClockTrue)) else $error("select moved off clock fall");
    a_gate_on_write: assert property (ctrlDataOe |-> clockGate)
        else $error("gate low during write data");
    a_gate_on_read: assert property (devDataOe |-> clockGate)
        else $error("gate low during read data");
    a_rstrobe_aligned: assert property ($changed(read_strobe) |->
        devDataOe) else $error("read strobe moved without data");
    a_lanes_equal: assert property (read_strobe inside {4'h0, 4'hF} &&
        write_strobe inside {4'h0, 4'hF}) else $error("lane strobes differ");
    a_wstrobe_centre: assert property ($changed(write_strobe) |->
        ctrlDataOe && $stable(ctrlData))
        else $error("write strobe not inside data eye");
    a_one_driver: assert property (!(ctrlDataOe && devDataOe))
        else $error("both ends drive data");
    a_gate_quiets: assert property (!clockGate [*4] |-> !devDataOe)
        else $error("drivers on while gate low");
    a_scan_quiets: assert property (scan_mode_pin [*4] |-> !devDataOe)
        else $error("drivers on in scan mode");

    // Main traffic kinds seen at least once
    c_write: cover property ($rose(ctrlDataOe));
    c_read: cover property ($rose(devDataOe));
    c_gate: cover property ($fell(clockGate));
    c_scan: cover property ($rose(scan_mode_pin));
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import gpi_pkg::*;
    logic sys_clk; // System clock
    logic rst; // Synchronous reset
    logic reqValid, gateReq, scanReq, reqReady, rdValid; // Request side
    gpi_cmd_t reqCmd; // Requested command
    logic [2:0] reqBank; // Requested bank
    logic [11:0] reqAddr; // Requested address
    logic [127:0] reqData, rdData; // Burst data
    logic [15:0] reqMask; // Burst mask
    gpi_power_t powerState; // Device power state
    logic cmdStrobe, scanActive; // Device status
    gpi_cmd_t cmdCode; // Last decoded command
    logic [7:0] openBanks; // Open rows
    logic [11:0] modeReg, extModeReg; // Mode registers
    int n_fail; // Mismatches
    int n_tests; // Comparisons

    gpi_link_if link();
    gpi_ctrl i_gpi_ctrl(.sys_clk(sys_clk), .rst(rst), .link(link),
        .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank),
        .reqAddr(reqAddr), .reqData(reqData), .reqMask(reqMask),
        .gateReq(gateReq), .scanReq(scanReq), .reqReady(reqReady),
        .rdData(rdData), .rdValid(rdValid));
    gpi_device i_gpi_device(.sys_clk(sys_clk), .rst(rst), .link(link),
        .powerState(powerState), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
        .openBanks(openBanks), .modeReg(modeReg), .extModeReg(extModeReg),
        .scanActive(scanActive));
    gpi_link_chk i_gpi_link_chk(.sys_clk(sys_clk), .rst(rst),
        .diffClockTrue(link.diffClockTrue),
        .diffClockComp(link.diffClockComp), .clockGate(link.clockGate),
        .chipSelN(link.chipSelN), .write_strobe(link.write_strobe),
        .read_strobe(link.read_strobe), .scan_mode_pin(link.scan_mode_pin),
        .ctrlData(link.ctrlData), .ctrlDataOe(link.ctrlDataOe),
        .devDataOe(link.devDataOe));

    // Free-running system clock
    always #20 sys_clk = ~sys_clk;

    // Compare and count
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One request; held until taken, then waits for the decode pulse
    task automatic issue(input gpi_cmd_t cmd, input logic [2:0] bank,
        input logic [11:0] addr, input logic [127:0] data,
        input logic [15:0] mask, input logic gateAfter, output logic got);
        int k;
        got = 1'b0;
        @(negedge sys_clk);
        reqValid = 1'b1;
        reqCmd = cmd;
        reqBank = bank;
        reqAddr = addr;
        reqData = data;
        reqMask = mask;
        for (k = 0; k < 300 && reqReady !== 1'b1; k++)
            @(negedge sys_clk);
        check(128'(k < 300), 128'h1);
        @(negedge sys_clk);
        reqValid = 1'b0;
        gateReq = gateAfter;
        // Idle periods decode a NOP too; watch only this command's window
        for (k = 0; k < 10 && !got; k++)
        begin
            @(negedge sys_clk);
            got = (cmdStrobe === 1'b1);
        end
        @(negedge sys_clk);
    endtask

    // Bounded wait for a power state, then judge it
    task automatic wait_state(input gpi_power_t exp);
        int k;
        for (k = 0; k < 80 && powerState !== exp; k++)
            @(negedge sys_clk);
        check(128'(powerState), 128'(exp));
    endtask

    // Base and extended mode loads
    task automatic t_mode();
        logic got;
        issue(GPI_CMD_LMR, 3'h0, 12'h123, '0, '0, 1'b1, got);
        check(128'(modeReg), 128'h123);
        issue(GPI_CMD_LMR, 3'h1, 12'h456, '0, '0, 1'b1, got);
        check(128'(extModeReg), 128'h456);
        check(128'(modeReg), 128'h123);
        check(128'(cmdCode), 128'(GPI_CMD_LMR));
    endtask

    // Row opening and both precharge forms
    task automatic t_rows();
        logic got;
        issue(GPI_CMD_ACT, 3'h5, 12'hABC, '0, '0, 1'b1, got);
        check(128'(openBanks), 128'h20);
        issue(GPI_CMD_ACT, 3'h2, 12'hFFF, '0, '0, 1'b1, got);
        check(128'(openBanks), 128'h24);
        issue(GPI_CMD_PRE, 3'h5, 12'hEFF, '0, '0, 1'b1, got);
        check(128'(openBanks), 128'h04);
        issue(GPI_CMD_ACT, 3'h7, 12'h001, '0, '0, 1'b1, got);
        check(128'(openBanks), 128'h84);
        issue(GPI_CMD_PRE, 3'h0, 12'h100, '0, '0, 1'b1, got);
        check(128'(openBanks), 128'h00);
    endtask

    // Full write, masked overwrite, read back with auto precharge
    task automatic t_data();
        logic got;
        logic [127:0] d0, d1, exp;
        int i;
        d0 = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
        d1 = 128'hFFEEDDCC_BBAA9988_77665544_33221100;
        issue(GPI_CMD_ACT, 3'h3, 12'h055, '0, '0, 1'b1, got);
        issue(GPI_CMD_WR, 3'h3, 12'h004, d0, 16'h0000, 1'b1, got);
        issue(GPI_CMD_WR, 3'h3, 12'h004, d1, 16'h0421, 1'b1, got);
        for (i = 0; i < 16; i++)
            exp[8*i+:8] = (16'h0421 >> i) & 1 ? d0[8*i+:8] : d1[8*i+:8];
        issue(GPI_CMD_RD, 3'h3, 12'h104, '0, '0, 1'b1, got);
        for (i = 0; i < 100 && rdValid !== 1'b1; i++)
            @(negedge sys_clk);
        check(128'(rdValid), 128'h1);
        check(rdData, exp);
        check(128'(openBanks), 128'h00);
    endtask

    // Deselect ignored, idle codes harmless, refresh decoded
    task automatic t_codes();
        logic got;
        issue(GPI_CMD_DESEL, 3'h1, 12'h000, '0, '0, 1'b1, got);
        check(128'(got), 128'h0);
        issue(GPI_CMD_NOP, 3'h1, 12'h000, '0, '0, 1'b1, got);
        issue(GPI_CMD_BST, 3'h1, 12'h000, '0, '0, 1'b1, got);
        check(128'(openBanks), 128'h00);
        issue(GPI_CMD_REF, 3'h0, 12'h000, '0, '0, 1'b1, got);
        check(128'(cmdCode), 128'(GPI_CMD_REF));
    endtask

    // Both power-downs and self refresh, each left again
    task automatic t_power();
        logic got;
        issue(GPI_CMD_ACT, 3'h1, 12'h010, '0, '0, 1'b0, got);
        wait_state(GPI_PD_ACT);
        gateReq = 1'b1;
        wait_state(GPI_ACTIVE);
        issue(GPI_CMD_PRE, 3'h0, 12'h100, '0, '0, 1'b0, got);
        wait_state(GPI_PD_PRE);
        gateReq = 1'b1;
        wait_state(GPI_ACTIVE);
        issue(GPI_CMD_REF, 3'h0, 12'h000, '0, '0, 1'b0, got);
        wait_state(GPI_SELF);
        gateReq = 1'b1;
        wait_state(GPI_ACTIVE);
    endtask

    // Scan pin in and out; sync delay is a few cycles
    task automatic t_scan();
        scanReq = 1'b1;
        repeat (8) @(negedge sys_clk);
        check(128'(scanActive), 128'h1);
        scanReq = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(128'(scanActive), 128'h0);
    endtask

    // Main sequence; inputs change on falling edges only
    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {reqValid, scanReq, reqBank, reqAddr, reqData, reqMask} = '0;
        gateReq = 1'b1;
        reqCmd = GPI_CMD_NOP;
        n_fail = 0;
        n_tests = 0;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_mode();
        t_rows();
        t_data();
        t_codes();
        t_power();
        t_scan();
        stop_test();
    end

    // Hang guard, well beyond the expected few hundred cycles
    initial
    begin
        #(40 * 20000);
        n_fail++;
        stop_test();
    end
endmodule
